// [verilog/spdc_pkg.sv]
// Package of constants and types for the switch port device-control bank.
package spdc_pkg;

	// ==========================================================
	// Register map and field layout.
	localparam logic [7:0] SPDC_DEVCTL_OFS   = 8'h08;
	localparam logic [7:0] SPDC_STATUS_OFS   = 8'h0C;
	localparam int         SPDC_TAG_BIT      = 8;
	localparam int         SPDC_PHANTOM_BIT  = 9;
	localparam int         SPDC_STANDBY_BIT  = 10;
	localparam int         SPDC_NOSNOOP_BIT  = 11;
	localparam int         SPDC_PAYLOAD_LSB  = 5;
	localparam int         SPDC_READREQ_LSB  = 12;

	// ==========================================================
	// Reset values and the supported payload ceiling.
	localparam logic [2:0] SPDC_PAYLOAD_RST  = 3'h0;
	localparam logic [2:0] SPDC_PAYLOAD_MAX  = 3'h1;
	localparam logic       SPDC_PHANTOM_RST  = 1'h0;
	localparam logic       SPDC_STANDBY_RST  = 1'h0;
	localparam logic [2:0] SPDC_READREQ_FIX  = 3'h0;

	// Writable fields of the bank, carried together.
	typedef struct packed {
		logic       standby_power_draw_enable;
		logic       phantom_enable;
		logic [2:0] max_payload;
	} spdc_ctl_s;

endpackage

// [verilog/spdc_bank.sv]
// Device-control register bank of one switch port.
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
// Notes on behaviour
// - The payload size field is three writable bits reset to zero, clamped to the supported size.
// - The extended tag enable does nothing, reads as zero and resets to zero.
// - The phantom function enable is an ordinary read-write bit that resets to zero.
// - The standby power draw enable is sticky, resets to zero and grants standby power when set.
// - The no-snoop enable always reads as zero.
// - The read request size field is fixed at zero.
module spdc_bank
	import spdc_pkg::*;
(
	// Clock and resets.
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        rst_sticky,
	// Register port.
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata,
	// Control outputs.
	output logic      [2:0]  max_payload,
	output logic             phantom_enable,
	output logic             standby_power_draw_enable
);

	// ==========================================================
	// Decode.
	spdc_ctl_s   ctl_q;
	spdc_ctl_s   ctl_wr;
	logic [31:0] rdata_q;
	wire         hit_ctl    = addr == SPDC_DEVCTL_OFS;
	wire         hit_stat   = addr == SPDC_STATUS_OFS;
	wire         wr_ctl     = wr && hit_ctl;
	wire         rd_ctl     = rd && hit_ctl;
	wire         rd_stat    = rd && hit_stat;
	wire         rd_other   = rd && !hit_ctl && !hit_stat;
	wire         wr_other   = wr && !hit_ctl;
	wire  [2:0]  wr_pay     = wdata[SPDC_PAYLOAD_LSB +: 3];
	wire         wr_phantom = wdata[SPDC_PHANTOM_BIT];
	wire         wr_standby = wdata[SPDC_STANDBY_BIT];
	// Oversized requests land on the ceiling rather than being refused.
	wire  [2:0]  pay_d      = (wr_pay > SPDC_PAYLOAD_MAX) ? SPDC_PAYLOAD_MAX : wr_pay;

	// Bits that software may not set never reach the flip-flops at all.
	assign ctl_wr = {wr_standby, wr_phantom, pay_d};

	// ==========================================================
	// Read images.
	// Each read-only field of the control word is built from a constant, so no write can ever reach it.
	wire  [31:0] img_pay     = 32'(ctl_q.max_payload) << SPDC_PAYLOAD_LSB;
	wire  [31:0] img_tag     = 32'(1'b0) << SPDC_TAG_BIT;
	wire  [31:0] img_phantom = 32'(ctl_q.phantom_enable) << SPDC_PHANTOM_BIT;
	wire  [31:0] img_standby = 32'(ctl_q.standby_power_draw_enable) << SPDC_STANDBY_BIT;
	wire  [31:0] img_nosnoop = 32'(1'b0) << SPDC_NOSNOOP_BIT;
	wire  [31:0] img_readreq = 32'(SPDC_READREQ_FIX) << SPDC_READREQ_LSB;
	wire  [31:0] ctl_image   = img_pay | img_tag | img_phantom
	                           | img_standby | img_nosnoop | img_readreq;
	wire  [31:0] stat_img    = {29'h0000_0000, ctl_q.standby_power_draw_enable,
	                           ctl_q.phantom_enable, |ctl_q.max_payload};
	wire  [31:0] rd_mux      = hit_ctl ? ctl_image : (hit_stat ? stat_img : 32'h0000_0000);
	// Read data last one cycle; an idle port shows zero so stale data never linger.
	wire  [31:0] rdata_d     = rd ? rd_mux : 32'h0000_0000;

	// ==========================================================
	// Control fields.
	// Both resets share this process so that the register keeps a single driver.
	always_ff @(posedge clock) begin
		if (rst) begin
			ctl_q.max_payload    <= SPDC_PAYLOAD_RST;
			ctl_q.phantom_enable <= SPDC_PHANTOM_RST;
		end else if (wr_ctl) begin
			ctl_q.max_payload    <= ctl_wr.max_payload;
			ctl_q.phantom_enable <= ctl_wr.phantom_enable;
		end
		// Sticky field: only the sticky reset clears it, so a link reset keeps the grant.
		if (rst_sticky) begin
			ctl_q.standby_power_draw_enable <= SPDC_STANDBY_RST;
		end else if (wr_ctl) begin
			ctl_q.standby_power_draw_enable <= ctl_wr.standby_power_draw_enable;
		end
	end

	// ==========================================================
	// Read data.
	always_ff @(posedge clock) begin
		if (rst) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign rdata                     = rdata_q;
	assign max_payload               = ctl_q.max_payload;
	assign phantom_enable            = ctl_q.phantom_enable;
	assign standby_power_draw_enable = ctl_q.standby_power_draw_enable;

	// ==========================================================
	// Checks on the payload field.
	payload_clamp_a: assert property (@(posedge clock) disable iff (rst || rst_sticky)
		wr_ctl
		|=> max_payload == (($past(wdata[7:5]) > SPDC_PAYLOAD_MAX) ? SPDC_PAYLOAD_MAX
		                    : $past(wdata[7:5])))
		else $error("payload field not clamped");

	payload_reset_a: assert property (@(posedge clock)
		rst
		|=> max_payload == SPDC_PAYLOAD_RST)
		else $error("payload not reset");

	payload_ceiling_a: assert property (@(posedge clock) disable iff (rst)
		max_payload <= SPDC_PAYLOAD_MAX)
		else $error("payload above ceiling");

	payload_hold_a: assert property (@(posedge clock) disable iff (rst)
		!wr_ctl
		|=> $stable(max_payload))
		else $error("payload changed without a write");

	payload_read_a: assert property (@(posedge clock) disable iff (rst)
		rd_ctl
		|=> rdata[SPDC_PAYLOAD_LSB +: 3] == $past(max_payload))
		else $error("payload not readable");

	// ==========================================================
	// Checks on the extended tag enable.
	tag_zero_a: assert property (@(posedge clock) disable iff (rst)
		rd_ctl
		|=> rdata[SPDC_TAG_BIT] == 1'b0)
		else $error("tag enable reads one");

	// ==========================================================
	// Checks on the phantom function enable.
	phantom_rw_a: assert property (@(posedge clock) disable iff (rst)
		wr_ctl
		|=> phantom_enable == $past(wdata[9]))
		else $error("phantom bit not written");

	phantom_reset_a: assert property (@(posedge clock)
		rst
		|=> !phantom_enable)
		else $error("phantom bit not reset");

	phantom_hold_a: assert property (@(posedge clock) disable iff (rst)
		!wr_ctl
		|=> $stable(phantom_enable))
		else $error("phantom bit changed without a write");

	phantom_read_a: assert property (@(posedge clock) disable iff (rst)
		rd_ctl
		|=> rdata[SPDC_PHANTOM_BIT] == $past(phantom_enable))
		else $error("phantom bit not readable");

	// ==========================================================
	// Checks on the sticky standby power grant and the status word.
	sticky_keep_a: assert property (@(posedge clock) disable iff (rst_sticky)
		rst && !wr
		|=> $stable(standby_power_draw_enable))
		else $error("sticky bit lost on reset");

	read_echo_a: assert property (@(posedge clock) disable iff (rst || rst_sticky)
		rd_ctl
		|=> rdata[10] == standby_power_draw_enable)
		else $error("sticky bit not readable");

	sticky_write_a: assert property (@(posedge clock) disable iff (rst_sticky)
		wr_ctl
		|=> standby_power_draw_enable == $past(wdata[SPDC_STANDBY_BIT]))
		else $error("sticky bit not written");

	sticky_reset_a: assert property (@(posedge clock)
		rst_sticky
		|=> !standby_power_draw_enable)
		else $error("sticky bit not cleared");

	sticky_hold_a: assert property (@(posedge clock) disable iff (rst_sticky)
		!wr_ctl
		|=> $stable(standby_power_draw_enable))
		else $error("sticky bit changed without a write");

	status_image_a: assert property (@(posedge clock) disable iff (rst)
		rd_stat
		|=> rdata[2:0] == {$past(standby_power_draw_enable), $past(phantom_enable),
		                   $past(|max_payload)})
		else $error("status word wrong");

	// ==========================================================
	// Checks on the fields fixed at zero.
	snoop_zero_a: assert property (@(posedge clock) disable iff (rst)
		rd_ctl
		|=> rdata[SPDC_NOSNOOP_BIT] == 1'b0)
		else $error("no-snoop reads one");

	readreq_zero_a: assert property (@(posedge clock) disable iff (rst)
		rd_ctl
		|=> rdata[SPDC_READREQ_LSB +: 3] == SPDC_READREQ_FIX)
		else $error("read request size not zero");

	// ==========================================================
	// Checks on ignored writes and the read port.
	ctl_ignore_a: assert property (@(posedge clock) disable iff (rst || rst_sticky)
		wr_other
		|=> $stable(max_payload) && $stable(phantom_enable) && $stable(standby_power_draw_enable))
		else $error("write elsewhere changed control");

	spare_zero_a: assert property (@(posedge clock) disable iff (rst)
		rd_ctl
		|=> rdata[31:15] == 17'h0_0000 && rdata[4:0] == 5'h00)
		else $error("spare control bits not zero");

	stat_upper_a: assert property (@(posedge clock) disable iff (rst)
		rd_stat
		|=> rdata[31:3] == 29'h0000_0000)
		else $error("spare status bits not zero");

	unmapped_zero_a: assert property (@(posedge clock) disable iff (rst)
		rd_other
		|=> rdata == 32'h0000_0000)
		else $error("unmapped read not zero");

	rdata_idle_a: assert property (@(posedge clock) disable iff (rst)
		!rd
		|=> rdata == 32'h0000_0000)
		else $error("read data outlived the read");

endmodule

// [testbench/spdc_bank_bench.sv]
// Self-checking bench for the switch port device-control bank.
`timescale 1ns/100ps
module spdc_bank_bench
	import spdc_pkg::*;
;
	logic        clock = 1'h0, rst = 1'h1, rst_sticky = 1'h1, wr = 1'h0, rd = 1'h0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] rdata;
	logic [2:0]  max_payload;
	logic        phantom_enable, standby_power_draw_enable;
	int          fail_count = 0, checks = 0;

	spdc_bank dut (.clock, .rst, .rst_sticky, .addr, .wdata, .wr, .rd, .rdata,
		.max_payload, .phantom_enable, .standby_power_draw_enable);

	// ==========================================================
	// Access tasks.
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		wr <= 1'h1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr <= 1'h0;
	endtask
	// Read data stand only in the cycle after the strobe, so sample just past that edge.
	task rd_chk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		rd <= 1'h1;
		addr <= a;
		@(posedge clock);
		rd <= 1'h0;
		#1 chk(rdata, e);
	endtask
	task test_done;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// ==========================================================
	// Clock, watchdog and tests.
	initial begin
		forever #2 clock = ~clock;
	end
	initial begin
		#2000;
		fail_count++;
		test_done();
	end
	initial begin
		repeat (4) @(posedge clock);
		rst <= 1'h0;
		rst_sticky <= 1'h0;
		rd_chk(SPDC_DEVCTL_OFS, 32'h0000_0000);
		wr_reg(SPDC_DEVCTL_OFS, 32'hFFFF_FFFF);
		rd_chk(SPDC_DEVCTL_OFS, 32'h0000_0620);
		chk({29'h0, max_payload}, {29'h0, SPDC_PAYLOAD_MAX});
		chk({30'h0, phantom_enable, standby_power_draw_enable}, 32'h0000_0003);
		rd_chk(SPDC_STATUS_OFS, 32'h0000_0007);
		wr_reg(SPDC_DEVCTL_OFS, 32'h0000_0000);
		rd_chk(SPDC_DEVCTL_OFS, 32'h0000_0000);
		wr_reg(SPDC_DEVCTL_OFS, 32'h0000_0420);
		rd_chk(SPDC_DEVCTL_OFS, 32'h0000_0420);
		wr_reg(SPDC_DEVCTL_OFS, 32'h0000_0620);
		@(posedge clock);
		rst <= 1'h1;
		@(posedge clock);
		rst <= 1'h0;
		rd_chk(SPDC_DEVCTL_OFS, 32'h0000_0400);
		wr_reg(SPDC_STATUS_OFS, 32'hFFFF_FFFF);
		rd_chk(SPDC_STATUS_OFS, 32'h0000_0004);
		rd_chk(8'h10, 32'h0000_0000);
		@(posedge clock);
		rst_sticky <= 1'h1;
		@(posedge clock);
		rst_sticky <= 1'h0;
		rd_chk(SPDC_DEVCTL_OFS, 32'h0000_0000);
		test_done();
	end
endmodule
